// >>> core/sld_top.sv
// Stall load detect top: result capture, pulse output, register slave.
// Assumes full-step strobe and measurement arrive synchronous to the clock.
// Register map: stall threshold, velocity gate, held result, live status.
// The full-step strobe is one clock wide; a longer strobe recaptures.
`timescale 1ns/1ns
module sld_top
  import sld_pkg::*;
(
  input wire logic i_ref_clk,                   // 10 MHz clock
  input wire logic i_rstn,                      // Synchronous reset, active low
  input wire logic i_full_step,                 // One-cycle pulse per full step
  input wire logic [RESULT_W-1:0] i_load_raw,   // Raw load measurement
  input wire logic i_quiet_mode,                // Quiet chopper active
  input wire logic [VEL_W-1:0] i_step_interval_measure, // Step interval
  output logic o_fault_pulse_out,               // Stall pulse to controller
  output logic [RESULT_W-1:0] o_load_measure_result,    // Latest result
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  // All flops reset synchronously; both settings clear to zero
  logic [THRESH_W-1:0] stall_threshold;          // Software setting
  logic [VEL_W-1:0] lower_velocity_threshold;    // Software setting
  logic [RESULT_W-1:0] load_measure_result;      // Held per full step
  logic step_seen;                               // Result is fresh this cycle
  logic [7:0] aw_addr;                           // Captured write address
  logic aw_held;                                 // Write address taken
  logic [31:0] w_data;                           // Captured write data
  logic [3:0] w_strb;                            // Captured strobes
  logic w_held;                                  // Write data taken
  logic stall;                                   // Result below doubled threshold
  logic gate;                                    // Quiet mode and velocity gate open

  // ----------------------------------------
  // Result capture
  // ----------------------------------------
  // Clamp guards against a raw 511 from the analog front end
  wire logic [RESULT_W-1:0] next_result =
    (i_load_raw > RESULT_MAX) ? RESULT_MAX : i_load_raw;

  // Update only on full steps, never per clock
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      load_measure_result <= RST_RESULT;
      step_seen <= 1'b0;
    end else begin
      if (i_full_step) begin
        load_measure_result <= next_result;
      end
      // Marks the cycle in which the fresh result is judged
      step_seen <= i_full_step;
    end
  end

  // ----------------------------------------
  // Stall comparison
  // ----------------------------------------
  // Works on the held result, so a pulse always matches a readable value
  sld_compare u_cmp (
    .i_result(load_measure_result),
    .i_threshold(stall_threshold),
    .i_vel_thresh(lower_velocity_threshold),
    .i_step_interval(i_step_interval_measure),
    .i_quiet_mode(i_quiet_mode),
    .o_stall(stall),
    .o_gate(gate)
  );

  // ----------------------------------------
  // Pulse output
  // ----------------------------------------
  // One pulse per evaluated full step; a single pulse is enough downstream
  // A stall that lasts many steps pulses on each of them, not only once
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_fault_pulse_out <= 1'b0;
    end else begin
      // Registered, so the controller sees a clean one-cycle pulse
      o_fault_pulse_out <= step_seen && stall && gate;
    end
  end

  // The result is a flop already, so the output needs no extra stage
  assign o_load_measure_result = load_measure_result;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Shared by both paths so reads and writes agree on the map
  function automatic logic addr_mapped(input logic [7:0] addr);
    addr_mapped = (addr == OFS_THRESH) || (addr == OFS_VEL)
      || (addr == OFS_RESULT) || (addr == OFS_STATUS);
  endfunction : addr_mapped

  // ----------------------------------------
  // AXI write path
  // ----------------------------------------
  // Ready only while the beat's holder is free and no response waits
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  wire logic aw_take = s_axi_awvalid && s_axi_awready;
  wire logic w_take = s_axi_wvalid && s_axi_wready;
  // Merge a beat taken now with one held from earlier
  wire logic [7:0] wr_addr = aw_take ? s_axi_awaddr : aw_addr;
  wire logic [31:0] wr_data = w_take ? s_axi_wdata : w_data;
  wire logic [3:0] wr_strb = w_take ? s_axi_wstrb : w_strb;
  wire logic wr_go = (aw_take || aw_held) && (w_take || w_held);
  // Register selects, qualified by a complete write
  wire logic wr_thresh = wr_go && (wr_addr == OFS_THRESH);
  wire logic wr_vel = wr_go && (wr_addr == OFS_VEL);
  wire logic wr_ok = addr_mapped(wr_addr);

  // Address and data may arrive in either order; response follows both
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      // Nothing held and no response pending
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (wr_go) begin
        // Both beats present: respond and free the holders
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else begin
        // Keep whichever beat arrived first
        if (aw_take) begin
          aw_held <= 1'b1;
          aw_addr <= s_axi_awaddr;
        end
        if (w_take) begin
          w_held <= 1'b1;
          w_data <= s_axi_wdata;
          w_strb <= s_axi_wstrb;
        end
        // The response leaves once the master takes it
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // Register writes honour byte strobes
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      // Settings return to their reset values
      stall_threshold <= RST_THRESH;
      lower_velocity_threshold <= RST_VEL;
    end else begin
      // Only byte lane 0 carries threshold bits
      if (wr_thresh && wr_strb[0]) begin
        stall_threshold <= wr_data[7:0];
      end
      // Velocity gate spans three lanes; bits above 19 are dropped
      if (wr_vel) begin
        if (wr_strb[0]) lower_velocity_threshold[7:0] <= wr_data[7:0];
        if (wr_strb[1]) lower_velocity_threshold[15:8] <= wr_data[15:8];
        if (wr_strb[2]) lower_velocity_threshold[19:16] <= wr_data[19:16];
      end
    end
  end

  // ----------------------------------------
  // AXI read path
  // ----------------------------------------
  // One read in flight; a new address is taken once the data is gone
  assign s_axi_arready = !s_axi_rvalid;
  wire logic ar_take = s_axi_arvalid && s_axi_arready;
  // Live status, as the comparator sees it in this cycle
  wire logic [31:0] rd_status = {29'h0000_0000, gate, stall, i_quiet_mode};
  wire logic rd_ok = addr_mapped(s_axi_araddr);
  // Unmapped offsets read as zero
  wire logic [31:0] rd_mux =
    (s_axi_araddr == OFS_THRESH) ? {24'h00_0000, stall_threshold} :
    (s_axi_araddr == OFS_VEL) ? {12'h000, lower_velocity_threshold} :
    (s_axi_araddr == OFS_RESULT) ? {23'h00_0000, load_measure_result} :
    (s_axi_araddr == OFS_STATUS) ? rd_status : 32'h0000_0000;

  // Data captured at address acceptance, held until taken
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (ar_take) begin
      // Data and response are captured together at acceptance
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      // The master took the data
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : sld_top

// >>> core/sld_pkg.sv
// Constants and types for the stall load detect block.
// Assumes a single 10 MHz clock and an AXI4-Lite register bus.
package sld_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int RESULT_W = 9;  // Holds 0..510
  localparam int THRESH_W = 8;  // Stall threshold width
  localparam int VEL_W = 20;    // Velocity threshold and step interval

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_THRESH = 8'h00;   // Stall threshold, RW
  localparam logic [7:0] OFS_VEL = 8'h04;      // Lower velocity threshold, RW
  localparam logic [7:0] OFS_RESULT = 8'h08;   // Load measure result, RO
  localparam logic [7:0] OFS_STATUS = 8'h0C;   // Live status bits, RO

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [THRESH_W-1:0] RST_THRESH = 8'h00;
  localparam logic [VEL_W-1:0] RST_VEL = 20'h0_0000;
  localparam logic [RESULT_W-1:0] RST_RESULT = 9'h000;
  localparam logic [RESULT_W-1:0] RESULT_MAX = 9'h1FE;  // 510

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : sld_pkg

// >>> core/sld_compare.sv
// Stall comparator and pulse gate.
// Assumes the result and threshold are stable registered values.
`timescale 1ns/1ns
module sld_compare
  import sld_pkg::*;
(
  input wire logic [RESULT_W-1:0] i_result,     // Latest load result
  input wire logic [THRESH_W-1:0] i_threshold,  // Stall threshold
  input wire logic [VEL_W-1:0] i_vel_thresh,    // Lower velocity threshold
  input wire logic [VEL_W-1:0] i_step_interval, // Measured step interval
  input wire logic i_quiet_mode,                // Quiet chopper active
  output logic o_stall,                         // Result below doubled threshold
  output logic o_gate                           // Pulse allowed
);

  // ----------------------------------------
  // Comparison
  // ----------------------------------------
  // Doubling is a shift, so the compare span matches 0..510
  wire logic [RESULT_W-1:0] doubled = {i_threshold, 1'b0};
  assign o_stall = (i_result < doubled);
  // Slow motion gives weak back EMF; gate the output there
  assign o_gate = i_quiet_mode && (i_vel_thresh >= i_step_interval);

endmodule : sld_compare

// >>> testbench/sld_checker.sv
// Checker for the stall load detect top, ports only.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
module sld_checker
  import sld_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_full_step,
  input wire logic [RESULT_W-1:0] i_load_raw,
  input wire logic i_quiet_mode,
  input wire logic o_fault_pulse_out,
  input wire logic [RESULT_W-1:0] o_load_measure_result
);
  // ---------------
  // Properties
  // ---------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  a_result_range: assert property (o_load_measure_result <= RESULT_MAX)
    else $error("result above range");
  a_result_capture: assert property (i_full_step |=> o_load_measure_result ==
    (($past(i_load_raw) > RESULT_MAX) ? RESULT_MAX : $past(i_load_raw)))
    else $error("result not captured");
  a_result_hold: assert property (!i_full_step |=> $stable(o_load_measure_result))
    else $error("result moved without step");
  // A pulse needs a step two edges back and the quiet chopper
  a_pulse_gate: assert property (o_fault_pulse_out |-> $past(i_full_step, 2) && $past(i_quiet_mode))
    else $error("pulse without gate");
  // Doubled 8-bit threshold tops out at 510, so a full result never stalls
  a_pulse_stall: assert property (o_fault_pulse_out |-> $past(o_load_measure_result) < RESULT_MAX)
    else $error("pulse on full result");
  c_pulse: cover property (o_fault_pulse_out);
  c_clamp: cover property (i_full_step && i_load_raw > RESULT_MAX);
  c_quiet_step: cover property (i_full_step && i_quiet_mode ##2 !o_fault_pulse_out);
endmodule : sld_checker

bind sld_top sld_checker u_sld_checker (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
  .i_full_step(i_full_step), .i_load_raw(i_load_raw), .i_quiet_mode(i_quiet_mode),
  .o_fault_pulse_out(o_fault_pulse_out), .o_load_measure_result(o_load_measure_result));

// >>> testbench/sld_ctrl_model.sv
// Motion controller model: latches a stop on any stall pulse.
// Assumes the pulse is one registered cycle wide.
`timescale 1ns/1ns
module sld_ctrl_model (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_fault_pulse_out,
  output logic o_stop
);
  // One pulse is enough to stop; no debounce
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) o_stop <= 1'b0;
    else if (i_fault_pulse_out) o_stop <= 1'b1;
  end
endmodule : sld_ctrl_model

// >>> testbench/tb_top.sv
// Bench for the stall load detect top over AXI4-Lite.
// Assumes flags are settled at the falling edge.
`timescale 1ns/1ns
module tb_top
  import sld_pkg::*;
;
  logic clk = 0, rstn = 0, fs = 0, quiet = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic [8:0] raw = '0, res;
  logic [19:0] ivl = '0;
  logic [7:0] awa = '0, ara = '0;
  logic [3:0] ws = 4'hF;
  logic [31:0] wd = '0, rdt, rdat;
  logic [1:0] br, rr, rsp;
  logic awr, wr, bv, arr, rv, pulse, stop;
  int bad_count = 0, n_tests = 0;
  always #50 clk = ~clk;
  sld_top u_sld_top (.i_ref_clk(clk), .i_rstn(rstn), .i_full_step(fs), .i_load_raw(raw),
    .i_quiet_mode(quiet), .i_step_interval_measure(ivl), .o_fault_pulse_out(pulse),
    .o_load_measure_result(res), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdt),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre));
  sld_ctrl_model u_sld_ctrl_model (.i_ref_clk(clk), .i_rstn(rstn),
    .i_fault_pulse_out(pulse), .o_stop(stop));
  task give_verdict;
    if (bad_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("[FAIL] %s exp %h got %h", nm, e, g);
      bad_count++;
    end
  endtask : chk
  task wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int k;
    logic at, wt, dn;
    @(posedge clk); awa <= a; wd <= d; ws <= s; awv <= 1; wv <= 1; bre <= 1;
    for (k = 0; k < 50; k++) begin
      @(negedge clk); at = awv && awr; wt = wv && wr; dn = bv; rsp = br;
      @(posedge clk); if (at) awv <= 0; if (wt) wv <= 0;
      if (dn) begin bre <= 0; break; end
    end
    if (k == 50) begin chk("timeout", 0, 1); give_verdict(); end
    else chk("bresp", RESP_OKAY, rsp);
  endtask : wr_reg
  task rd_reg(input logic [7:0] a);
    int k;
    logic at, dn;
    @(posedge clk); ara <= a; arv <= 1; rre <= 1;
    for (k = 0; k < 50; k++) begin
      @(negedge clk); at = arv && arr; dn = rv; rdat = rdt; rsp = rr;
      @(posedge clk); if (at) arv <= 0;
      if (dn) begin rre <= 0; break; end
    end
    if (k == 50) begin chk("timeout", 0, 1); give_verdict(); end
  endtask : rd_reg
  // Result shows one edge after the step, pulse one edge later
  task step(input logic [8:0] r, input logic [8:0] er, input logic ep);
    @(posedge clk); fs <= 1; raw <= r;
    @(posedge clk); fs <= 0;
    @(negedge clk); chk("result", {23'h0, er}, {23'h0, res});
    @(negedge clk); chk("pulse", {31'h0, ep}, {31'h0, pulse});
  endtask : step
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1;
    rd_reg(OFS_THRESH); chk("thresh_rst", 32'h0000_0000, rdat);
    rd_reg(8'h10); chk("unmapped", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    wr_reg(OFS_THRESH, 32'h0000_0080, 4'hF);
    wr_reg(OFS_VEL, 32'h0000_0100, 4'hF);
    rd_reg(OFS_VEL); chk("vel", 32'h0000_0100, rdat);
    chk("stop_idle", 0, {31'h0, stop});
    @(posedge clk); quiet <= 1; ivl <= 20'h0_0100;
    step(9'h0FF, 9'h0FF, 1);
    step(9'h100, 9'h100, 0);
    step(9'h1FF, 9'h1FE, 0);
    step(9'h000, 9'h000, 1);
    @(posedge clk); quiet <= 0;
    step(9'h000, 9'h000, 0);
    @(posedge clk); quiet <= 1; ivl <= 20'h0_0101;
    step(9'h000, 9'h000, 0);
    @(posedge clk); ivl <= 20'h0_0100;
    wr_reg(OFS_THRESH, 32'h0000_00FF, 4'hF);
    step(9'h1FD, 9'h1FD, 1);
    rd_reg(OFS_STATUS); chk("status_stall", 32'h0000_0007, rdat);
    step(9'h1FE, 9'h1FE, 0);
    rd_reg(OFS_RESULT); chk("result_reg", {23'h0, RESULT_MAX}, rdat);
    wr_reg(OFS_RESULT, 32'h0000_0000, 4'hF);
    rd_reg(OFS_RESULT); chk("result_ro", {23'h0, RESULT_MAX}, rdat);
    wr_reg(OFS_VEL, 32'h000F_FFFF, 4'h1);
    rd_reg(OFS_VEL); chk("vel_strb", 32'h0000_01FF, rdat);
    rd_reg(OFS_STATUS); chk("status_idle", 32'h0000_0005, rdat);
    chk("stop", 1, {31'h0, stop});
    give_verdict();
  end
endmodule : tb_top
